// >>> core/lbsb_pkg.sv
// Shared constants, carrier types and helpers for the bleeder and segment buffer block.
package lbsb_pkg;

  // ----------------------------------------------------------------------
  // Register map (byte addresses, one aligned 32-bit word each)
  // ----------------------------------------------------------------------
  localparam int ADDR_W = 8;
  localparam logic [7:0] OFF_DRIVER_ENABLE = 8'h00;
  localparam logic [7:0] OFF_BASE_FREQ = 8'h04;
  localparam logic [7:0] OFF_BLEEDER_CTRL = 8'h08;
  localparam logic [7:0] OFF_SEG_PAIR_ZERO = 8'h0C;

  // ----------------------------------------------------------------------
  // Field positions and widths
  // ----------------------------------------------------------------------
  localparam int DRV_EN_BIT = 0;
  localparam int BASE_FREQ_LSB = 0;
  localparam int BASE_FREQ_W = 4;
  localparam int SOURCE_BIT = 3;
  localparam int HIGH_RES_BIT = 4;
  localparam int LOW_RES_LSB = 5;
  localparam int LOW_RES_W = 3;
  localparam int SEG_ZERO_LSB = 0;
  localparam int SEG_ONE_LSB = 4;
  localparam int SEG_W = 4;

  // ----------------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------------
  localparam logic RST_DRIVER_ENABLE = 1'h0;
  localparam logic [3:0] RST_BASE_FREQ = 4'h0;
  localparam logic RST_SOURCE = 1'h0;
  localparam logic RST_HIGH_RES = 1'h0;
  localparam logic [2:0] RST_LOW_RES = 3'h0;
  localparam logic [3:0] RST_SEG = 4'h0;

  // ----------------------------------------------------------------------
  // Base frequency and window codes
  // ----------------------------------------------------------------------
  localparam logic [3:0] FREQ_SYS_FIRST = 4'h0;
  localparam logic [3:0] FREQ_SYS_LAST = 4'h4;
  localparam logic [3:0] FREQ_SLOW_A = 4'h8;
  localparam logic [3:0] FREQ_SLOW_B = 4'h9;
  localparam int SYS_SHIFT_MAX = 18;
  localparam int SLOW_SHIFT_A = 9;
  localparam int SLOW_SHIFT_B = 8;
  localparam int WIN_SHIFT_OFFSET = 8;
  localparam logic [2:0] WIN_NEVER = 3'h0;
  localparam logic [2:0] WIN_FIRST = 3'h1;
  localparam logic [2:0] WIN_LAST = 3'h5;
  localparam logic [2:0] WIN_ALWAYS = 3'h6;

  // ----------------------------------------------------------------------
  // Bus response codes and clock
  // ----------------------------------------------------------------------
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam int CLK_PERIOD_NS = 10;

  // ----------------------------------------------------------------------
  // Carrier types
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic awvalid;
    logic [ADDR_W-1:0] awaddr;
    logic wvalid;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bready;
    logic arvalid;
    logic [ADDR_W-1:0] araddr;
    logic rready;
  } lbsb_axi_req_t;

  typedef struct packed {
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } lbsb_axi_rsp_t;

  typedef struct packed {
    logic internalSourceSel;
    logic highResSel;
    logic lowResConnect;
    logic [3:0] segmentZeroData;
    logic [3:0] segmentOneData;
  } lbsb_glass_t;

  // ----------------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------------
  // True when the address hits one of the four mapped words.
  function automatic logic lbsbIsMapped(input logic [ADDR_W-1:0] addr);
    return (addr == OFF_DRIVER_ENABLE) || (addr == OFF_BASE_FREQ) ||
           (addr == OFF_BLEEDER_CTRL) || (addr == OFF_SEG_PAIR_ZERO);
  endfunction

  // True for a base frequency code that is not reserved.
  function automatic logic lbsbFreqValid(input logic [3:0] sel);
    return (sel <= FREQ_SYS_LAST) || (sel == FREQ_SLOW_A) || (sel == FREQ_SLOW_B);
  endfunction

  // True when the code divides the slow clock rather than the system clock.
  function automatic logic lbsbFreqSlow(input logic [3:0] sel);
    return (sel == FREQ_SLOW_A) || (sel == FREQ_SLOW_B);
  endfunction

  // Power of two by which the selected source clock is divided.
  function automatic int lbsbBaseShift(input logic [3:0] sel, input int sysMax);
    int s;
    s = sysMax - int'(sel);
    if (sel == FREQ_SLOW_A) begin
      s = SLOW_SHIFT_A;
    end else if (sel == FREQ_SLOW_B) begin
      s = SLOW_SHIFT_B;
    end
    return s;
  endfunction

endpackage

// >>> core/lbsb_base_tick.sv
// Base clock divider: source ticks and one base tick per base clock period.
`timescale 1ns/100ps

module lbsb_base_tick #(
  parameter int SysShiftMax = lbsb_pkg::SYS_SHIFT_MAX
) (
  // Clock, reset and freeze.
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic run,
  // Selection and slow clock edge.
  input wire logic [3:0] freqSel,
  input wire logic slowEdge,
  // Ticks.
  output logic srcTick,
  output logic baseTick
);
  import lbsb_pkg::*;

  typedef struct packed {
    logic [SysShiftMax-1:0] cnt;
    logic srcTick;
    logic baseTick;
  } lbsb_tick_state_t;

  lbsb_tick_state_t s_q;
  lbsb_tick_state_t s_d;
  logic srcEv;
  logic [SysShiftMax-1:0] mask;

  // Source event is every system cycle, or each rising slow clock edge; reserved codes stop it.
  always_comb begin
    srcEv = 1'b0;
    if (lbsbFreqValid(freqSel)) begin
      srcEv = lbsbFreqSlow(freqSel) ? slowEdge : 1'b1;
    end
    mask = (SysShiftMax'(1) << lbsbBaseShift(freqSel, SysShiftMax)) - SysShiftMax'(1);
    s_d = s_q;
    s_d.srcTick = 1'b0;
    s_d.baseTick = 1'b0;
    if (run) begin
      s_d.srcTick = srcEv;
      if (srcEv) begin
        // Compare with >= so a shorter divisor chosen mid-count still wraps.
        if (s_q.cnt >= mask) begin
          s_d.cnt = '0;
          s_d.baseTick = 1'b1;
        end else begin
          s_d.cnt = s_q.cnt + SysShiftMax'(1);
        end
      end
    end
  end

  // State register.
  always_ff @(posedge clk) begin
    if (rst) begin
      s_q <= '0;
    end else if (ce) begin
      s_q <= s_d;
    end
  end

  assign srcTick = s_q.srcTick;
  assign baseTick = s_q.baseTick;

endmodule

// >>> core/lbsb_top.sv
// Bleeder resistor control and first segment buffer with an AXI4-Lite register slave.
//
// Decided for this implementation: the register offsets and the AXI4-Lite slave port.
`timescale 1ns/100ps
// Overview of operation
// - Source bit picks external bleeder at zero, internal bleeder resistors at one.
// - Window field and high-resistance bit act only while internal source is selected.
// - Window 000 never, 001-101 timed from base clock, 110 always, 111 reserved.
// - High-resistance bit selects nominal 200k at zero, 500k at one, on an output.
// - Segment buffer bits 7 to 4 hold segment one data for commons three to zero.
// - Bits 3 to 0 hold segment zero data for commons three to zero; reset zero.
// - Base frequency code divides system clock 2^18..2^14 or slow clock 2^9, 2^8.
// - Driver enable low stops the other registers' clock; their settings are kept.

module lbsb_top #(
  parameter int SysShiftMax = lbsb_pkg::SYS_SHIFT_MAX
) (
  // Clock, reset and freeze.
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  // Register bus.
  input wire lbsb_pkg::lbsb_axi_req_t axiReq,
  output lbsb_pkg::lbsb_axi_rsp_t axiRsp,
  // Slow clock pin, asynchronous to clk.
  input wire logic slowClkPin,
  // Glass and bleeder network controls.
  output lbsb_pkg::lbsb_glass_t glass
);
  import lbsb_pkg::*;

  // ----------------------------------------------------------------------
  // State
  // ----------------------------------------------------------------------
  localparam int WIN_W = SysShiftMax - 2;

  typedef struct packed {
    lbsb_axi_rsp_t rsp;
    logic awHeld;
    logic [ADDR_W-1:0] awAddr;
    logic wHeld;
    logic [31:0] wData;
    logic [3:0] wStrb;
    logic driverEnable;
    logic [3:0] baseFreqSel;
    logic bleederSourceSel;
    logic highResValueSel;
    logic [2:0] lowResWindowSel;
    logic [3:0] segmentZeroData;
    logic [3:0] segmentOneData;
    logic slowSync1;
    logic slowSync2;
    logic slowPrev;
    logic winActive;
    logic [WIN_W-1:0] winCnt;
    lbsb_glass_t glass;
  } lbsb_state_t;

  lbsb_state_t s_q;
  lbsb_state_t s_d;
  logic slowEdge;
  logic srcTick;
  logic baseTick;
  logic timedWin;
  logic [WIN_W-1:0] winLen;
  logic [31:0] rdWord;

  // ----------------------------------------------------------------------
  // Base clock divider
  // ----------------------------------------------------------------------
  // Edge detect looks only at the second synchroniser stage.
  assign slowEdge = s_q.slowSync2 & ~s_q.slowPrev;

  lbsb_base_tick #(
    .SysShiftMax(SysShiftMax)
  ) u_base_tick (
    .clk(clk),
    .rst(rst),
    .ce(ce),
    .run(s_q.driverEnable),
    .freqSel(s_q.baseFreqSel),
    .slowEdge(slowEdge),
    .srcTick(srcTick),
    .baseTick(baseTick)
  );

  // ----------------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------------
  // Window length in source ticks is the base divisor scaled down by 2^8 and up by 2^code.
  always_comb begin
    timedWin = s_q.bleederSourceSel && lbsbFreqValid(s_q.baseFreqSel) &&
               (s_q.lowResWindowSel >= WIN_FIRST) && (s_q.lowResWindowSel <= WIN_LAST);
    winLen = WIN_W'(1) << (lbsbBaseShift(s_q.baseFreqSel, SysShiftMax) -
                           WIN_SHIFT_OFFSET + int'(s_q.lowResWindowSel));
  end

  // Read word assembly; reserved bits read as zero.
  always_comb begin
    rdWord = 32'h00000000;
    case (axiReq.araddr)
      OFF_DRIVER_ENABLE: begin
        rdWord[DRV_EN_BIT] = s_q.driverEnable;
      end
      OFF_BASE_FREQ: begin
        rdWord[BASE_FREQ_LSB +: BASE_FREQ_W] = s_q.baseFreqSel;
      end
      OFF_BLEEDER_CTRL: begin
        rdWord[LOW_RES_LSB +: LOW_RES_W] = s_q.lowResWindowSel;
        rdWord[HIGH_RES_BIT] = s_q.highResValueSel;
        rdWord[SOURCE_BIT] = s_q.bleederSourceSel;
      end
      OFF_SEG_PAIR_ZERO: begin
        rdWord[SEG_ONE_LSB +: SEG_W] = s_q.segmentOneData;
        rdWord[SEG_ZERO_LSB +: SEG_W] = s_q.segmentZeroData;
      end
      default: begin
        rdWord = 32'h00000000;
      end
    endcase
  end

  // Bus handshakes, register writes, window timing and output drive.
  always_comb begin
    s_d = s_q;
    // Two-stage synchroniser for the slow clock pin.
    s_d.slowSync1 = slowClkPin;
    s_d.slowSync2 = s_q.slowSync1;
    s_d.slowPrev = s_q.slowSync2;

    // Write address and data are captured independently, in either order.
    if (axiReq.awvalid && s_q.rsp.awready) begin
      s_d.awHeld = 1'b1;
      s_d.awAddr = axiReq.awaddr;
    end
    if (axiReq.wvalid && s_q.rsp.wready) begin
      s_d.wHeld = 1'b1;
      s_d.wData = axiReq.wdata;
      s_d.wStrb = axiReq.wstrb;
    end
    if (s_q.rsp.bvalid && axiReq.bready) begin
      s_d.rsp.bvalid = 1'b0;
    end
    if (s_q.awHeld && s_q.wHeld && !s_q.rsp.bvalid) begin
      s_d.awHeld = 1'b0;
      s_d.wHeld = 1'b0;
      s_d.rsp.bvalid = 1'b1;
      s_d.rsp.bresp = lbsbIsMapped(s_q.awAddr) ? RESP_OKAY : RESP_SLVERR;
      // All fields live in byte lane zero, so only that strobe matters.
      if (s_q.wStrb[0]) begin
        if (s_q.awAddr == OFF_DRIVER_ENABLE) begin
          s_d.driverEnable = s_q.wData[DRV_EN_BIT];
        end
        // With the driver disabled the other registers are unclocked: writes are dropped.
        if (s_q.driverEnable) begin
          case (s_q.awAddr)
            OFF_BASE_FREQ: begin
              s_d.baseFreqSel = s_q.wData[BASE_FREQ_LSB +: BASE_FREQ_W];
            end
            OFF_BLEEDER_CTRL: begin
              s_d.lowResWindowSel = s_q.wData[LOW_RES_LSB +: LOW_RES_W];
              s_d.highResValueSel = s_q.wData[HIGH_RES_BIT];
              s_d.bleederSourceSel = s_q.wData[SOURCE_BIT];
            end
            OFF_SEG_PAIR_ZERO: begin
              s_d.segmentOneData = s_q.wData[SEG_ONE_LSB +: SEG_W];
              s_d.segmentZeroData = s_q.wData[SEG_ZERO_LSB +: SEG_W];
            end
            default: begin
              s_d.driverEnable = s_d.driverEnable;
            end
          endcase
        end
      end
    end
    s_d.rsp.awready = !s_d.awHeld;
    s_d.rsp.wready = !s_d.wHeld;

    // Read channel: one read in flight, answered from a registered word.
    if (s_q.rsp.rvalid && axiReq.rready) begin
      s_d.rsp.rvalid = 1'b0;
    end
    if (axiReq.arvalid && s_q.rsp.arready) begin
      s_d.rsp.rvalid = 1'b1;
      s_d.rsp.rdata = rdWord;
      s_d.rsp.rresp = lbsbIsMapped(axiReq.araddr) ? RESP_OKAY : RESP_SLVERR;
    end
    s_d.rsp.arready = !s_d.rsp.rvalid;

    // Timed low-resistance window; frozen with the rest while the driver is off.
    if (s_q.driverEnable) begin
      if (!timedWin) begin
        s_d.winActive = 1'b0;
        s_d.winCnt = '0;
      end else if (baseTick) begin
        s_d.winActive = 1'b1;
        s_d.winCnt = winLen;
      end else if (s_q.winActive && srcTick) begin
        s_d.winCnt = s_q.winCnt - WIN_W'(1);
        if (s_q.winCnt == WIN_W'(1)) begin
          s_d.winActive = 1'b0;
        end
      end
    end

    // Outputs: the internal-only settings are masked when the external network is used.
    s_d.glass.internalSourceSel = s_d.bleederSourceSel;
    s_d.glass.highResSel = s_d.bleederSourceSel & s_d.highResValueSel;
    s_d.glass.lowResConnect = s_d.bleederSourceSel &&
                              ((s_d.lowResWindowSel == WIN_ALWAYS) ||
                               (timedWin && s_d.winActive));
    s_d.glass.segmentZeroData = s_d.segmentZeroData;
    s_d.glass.segmentOneData = s_d.segmentOneData;
  end

  // ----------------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (rst) begin
      s_q <= '0;
      s_q.driverEnable <= RST_DRIVER_ENABLE;
      s_q.baseFreqSel <= RST_BASE_FREQ;
      s_q.bleederSourceSel <= RST_SOURCE;
      s_q.highResValueSel <= RST_HIGH_RES;
      s_q.lowResWindowSel <= RST_LOW_RES;
      s_q.segmentZeroData <= RST_SEG;
      s_q.segmentOneData <= RST_SEG;
    end else if (ce) begin
      s_q <= s_d;
    end
  end

  assign axiRsp = s_q.rsp;
  assign glass = s_q.glass;

endmodule

// >>> verif/lbsb_top_monitor.sv
// Concurrent checks on the ports of the bleeder and segment buffer block.
`timescale 1ns/100ps
module lbsb_top_monitor (
  // Clock, reset and freeze.
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  // Register bus.
  input wire lbsb_pkg::lbsb_axi_req_t axiReq,
  input wire lbsb_pkg::lbsb_axi_rsp_t axiRsp,
  // Slow clock and glass controls.
  input wire logic slowClkPin,
  input wire lbsb_pkg::lbsb_glass_t glass
);
  import lbsb_pkg::*;
  default clocking cb @(posedge clk);
  endclocking

  // ----------------------------------------------------------------------
  // Reset and bleeder outputs
  // ----------------------------------------------------------------------
  // A reset edge with the clock running clears every glass control.
  property p_rst_clear;
    rst && ce |=> glass == '0 && !axiRsp.rvalid;
  endproperty
  a_rst_clear: assert property (p_rst_clear) else $error("glass not cleared by reset");
  property p_hi_ext;
    disable iff (rst) !glass.internalSourceSel |-> !glass.highResSel;
  endproperty
  a_hi_ext: assert property (p_hi_ext) else $error("high value leaks on external");
  // One cycle of grace: the window may drop a cycle after the source does.
  property p_lr_ext;
    disable iff (rst)
      !glass.internalSourceSel && !$past(glass.internalSourceSel) |-> !glass.lowResConnect;
  endproperty
  a_lr_ext: assert property (p_lr_ext) else $error("window active on external");

  // ----------------------------------------------------------------------
  // Register bus timing
  // ----------------------------------------------------------------------
  property p_rd_lat;
    disable iff (rst) axiReq.arvalid && axiRsp.arready && ce |=> axiRsp.rvalid;
  endproperty
  a_rd_lat: assert property (p_rd_lat) else $error("read answer late");
  property p_wr_lat;
    disable iff (rst)
      (axiReq.awvalid && axiRsp.awready && axiReq.wvalid && axiRsp.wready && ce) ##1 ce
      |=> axiRsp.bvalid;
  endproperty
  a_wr_lat: assert property (p_wr_lat) else $error("write answer late");
  property p_b_hold;
    disable iff (rst) axiRsp.bvalid && !(axiReq.bready && ce) |=>
      axiRsp.bvalid && $stable(axiRsp.bresp);
  endproperty
  a_b_hold: assert property (p_b_hold) else $error("write answer dropped");
  property p_r_hold;
    disable iff (rst) axiRsp.rvalid && !(axiReq.rready && ce) |=>
      axiRsp.rvalid && $stable(axiRsp.rdata);
  endproperty
  a_r_hold: assert property (p_r_hold) else $error("read answer dropped");
  property p_rsvd;
    disable iff (rst) axiRsp.rvalid |-> axiRsp.rdata[31:8] == 24'h0;
  endproperty
  a_rsvd: assert property (p_rsvd) else $error("upper bits not zero");
  property p_unmap;
    disable iff (rst) axiReq.arvalid && axiRsp.arready && ce &&
      (axiReq.araddr > 8'h0C || axiReq.araddr[1:0] != 2'h0) |=>
      axiRsp.rresp == RESP_SLVERR && axiRsp.rdata == 32'h0;
  endproperty
  a_unmap: assert property (p_unmap) else $error("unmapped read not refused");
endmodule

// >>> verif/lbsb_glass_model.sv
// Behavioural glass and bleeder network with its free-running slow oscillator.
`timescale 1ns/100ps
module lbsb_glass_model (
  // Controls from the driver.
  input wire lbsb_pkg::lbsb_glass_t glass,
  // Slow oscillator and resulting bias resistance.
  output logic slowClkPin,
  output int biasKohm
);
  import lbsb_pkg::*;
  // The oscillator runs free at 70 ns, with a phase unrelated to the system clock.
  initial begin
    slowClkPin = 1'b0;
    #3;
    forever #35 slowClkPin = ~slowClkPin;
  end
  // Nominal resistance seen by the glass; zero means the external network.
  always_comb begin
    biasKohm = 0;
    if (glass.internalSourceSel) biasKohm = glass.highResSel ? 500 : 200;
    if (glass.internalSourceSel && glass.lowResConnect) biasKohm = 1;
  end
endmodule

// >>> verif/lbsb_top_tb.sv
// Self-checking bench for the bleeder control and segment buffer block.
`timescale 1ns/100ps
module lbsb_top_tb;
  import lbsb_pkg::*;
  localparam int SSM = 11;
  logic clk = 0, rst = 1, ce = 1, jit = 0, slowClk;
  lbsb_axi_req_t rq = '0;
  lbsb_axi_rsp_t rs;
  lbsb_glass_t g;
  int error_cnt = 0, n_tests = 0, cyc = 0, seed = 32'h53466FE7, h, p, bk;
  logic [31:0] d, v;
  logic [1:0] r;
  int fs[3] = '{0, 8, 9};
  int fc[3] = '{5, 1, 3};

  lbsb_top #(.SysShiftMax(SSM)) dut (.clk(clk), .rst(rst), .ce(ce), .axiReq(rq), .axiRsp(rs),
    .slowClkPin(slowClk), .glass(g));
  lbsb_glass_model model (.glass(g), .slowClkPin(slowClk), .biasKohm(bk));

  // ----------------------------------------------------------------------
  // Clock, freeze jitter and hang guard
  // ----------------------------------------------------------------------
  always #5 clk = ~clk;
  // Random freezes stretch the handshakes so the bus is seen under stalls.
  always @(posedge clk) ce <= jit ? (($random(seed) & 3) != 0) : 1'b1;
  always @(posedge clk) begin
    cyc++;
    if (cyc == 90000) begin
      error_cnt++;
      complete_run();
    end
  end

  // ----------------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------------
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s, input int t = 0);
    n_tests++;
    if (!(s === e || (t > 0 && s + t >= e && s <= e + t))) begin
      error_cnt++;
      $display("mismatch %s expected %0h seen %0h", n, e, s);
    end
  endtask
  // Each bus task opens on a fresh edge so a strobe is never assigned twice at once.
  task automatic wr(input logic [7:0] a, input logic [31:0] dat);
    bit aw, w;
    aw = 0;
    w = 0;
    @(posedge clk);
    rq.awaddr <= a;
    rq.wdata <= dat;
    rq.wstrb <= 4'hF;
    rq.awvalid <= 1'b1;
    rq.wvalid <= 1'b1;
    rq.bready <= 1'b1;
    do begin
      @(posedge clk);
      aw |= rs.awready & ce;
      w |= rs.wready & ce;
      if (aw) rq.awvalid <= 1'b0;
      if (w) rq.wvalid <= 1'b0;
    end while (!(rs.bvalid === 1'b1 && ce));
    r = rs.bresp;
    rq.bready <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge clk);
    rq.araddr <= a;
    rq.arvalid <= 1'b1;
    rq.rready <= 1'b1;
    do begin
      @(posedge clk);
      if (rs.arready && ce) rq.arvalid <= 1'b0;
    end while (!(rs.rvalid === 1'b1 && ce));
    v = rs.rdata;
    r = rs.rresp;
    rq.rready <= 1'b0;
  endtask
  task automatic waitv(input logic l, inout int k);
    while (g.lowResConnect !== l && k < 9000) begin
      @(posedge clk);
      k++;
    end
  endtask
  // Width of one connection pulse and the spacing of their starts, in clock cycles.
  task automatic meas(output int hw, output int pw);
    int k, s;
    k = 0;
    waitv(1'b0, k);
    waitv(1'b1, k);
    s = k;
    waitv(1'b0, k);
    hw = k - s;
    waitv(1'b1, k);
    pw = k - s;
  endtask
  function automatic int eh(input int s, input int c);
    return s < 8 ? 1 << (SSM - s - 8 + c) : (1 << (9 - s + c)) * 7;
  endfunction
  function automatic int ep(input int s);
    return s < 8 ? 1 << (SSM - s) : (1 << (17 - s)) * 7;
  endfunction
  task automatic complete_run;
    $display("comparisons %0d mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // ----------------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------------
  initial begin
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    for (int a = 0; a < 4; a++) begin
      rd(8'(a * 4));
      chk("reset value", 32'h0, v);
    end
    rd(8'h10);
    chk("unmapped read resp", RESP_SLVERR, r);
    wr(8'h11, 32'hFF);
    chk("unmapped write resp", RESP_SLVERR, r);
    $display("test reset and map done");
    wr(OFF_DRIVER_ENABLE, 32'h1);
    jit = 1;
    // Segment buffer under random data, the all-ones word first.
    for (int i = 0; i < 8; i++) begin
      d = (i == 0) ? 32'hFFFFFFFF : $random(seed);
      wr(OFF_SEG_PAIR_ZERO, d);
      rd(OFF_SEG_PAIR_ZERO);
      chk("segment word", d & 32'hFF, v);
      chk("segment one", d[7:4], g.segmentOneData);
      chk("segment zero", d[3:0], g.segmentZeroData);
    end
    jit = 0;
    $display("test segment buffer done");
    for (int i = 0; i < 4; i++) begin
      wr(OFF_BLEEDER_CTRL, 32'(i << 3));
      rd(OFF_BLEEDER_CTRL);
      chk("bleeder word", 32'(i << 3), v);
      chk("source", i[0], g.internalSourceSel);
      chk("high value", i[0] & i[1], g.highResSel);
      // The network model turns the selects into the resistance the glass sees.
      chk("bias", i[0] ? (i[1] ? 500 : 200) : 0, bk);
    end
    $display("test bleeder select done");
    wr(OFF_BASE_FREQ, 32'h4);
    for (int c = 0; c < 8; c++) begin
      wr(OFF_BLEEDER_CTRL, 32'((c << 5) | 8));
      meas(h, p);
      chk("window width", (c >= 1 && c <= 5) ? eh(4, c) : 0, h);
      chk("window period", (c >= 1 && c <= 5) ? ep(4) : 0, p);
      chk("window level", c >= 1 && c <= 6, g.lowResConnect);
    end
    wr(OFF_BLEEDER_CTRL, 32'hC0);
    meas(h, p);
    chk("external window", 32'h0, g.lowResConnect);
    $display("test window codes done");
    for (int i = 0; i < 3; i++) begin
      wr(OFF_BASE_FREQ, 32'(fs[i]));
      rd(OFF_BASE_FREQ);
      chk("base word", 32'(fs[i]), v);
      wr(OFF_BLEEDER_CTRL, 32'((fc[i] << 5) | 8));
      meas(h, p);
      chk("base width", eh(fs[i], fc[i]), h, 2 * (fs[i] / 8));
      chk("base period", ep(fs[i]), p, 2 * (fs[i] / 8));
    end
    // A reserved base code stops the base clock, so the timed window never opens.
    wr(OFF_BASE_FREQ, 32'h5);
    meas(h, p);
    chk("reserved base width", 32'h0, h);
    chk("reserved base level", 32'h0, g.lowResConnect);
    $display("test base frequency done");
    wr(OFF_SEG_PAIR_ZERO, 32'hA5);
    wr(OFF_DRIVER_ENABLE, 32'h0);
    wr(OFF_SEG_PAIR_ZERO, 32'h3C);
    rd(OFF_SEG_PAIR_ZERO);
    chk("kept while off", 32'hA5, v);
    chk("glass while off", 4'hA, g.segmentOneData);
    $display("test disable done");
    complete_run();
  end
endmodule

bind lbsb_top lbsb_top_monitor mon (.clk(clk), .rst(rst), .ce(ce), .axiReq(axiReq),
  .axiRsp(axiRsp), .slowClkPin(slowClkPin), .glass(glass));
